// ==== hw/usr_pkg.sv ====
// Constants for the serial status, sync-pending and data port block
// Behaviour
// - Repeat limit sets bit 7, write one clears
// - Transmitter empty only in LIN master framing
// - Clash with detection enabled sets bit 5
// - Auto-baud sync field not 0x55 sets bit 4
// - Bit 3 shows synchronised CTS level with flow pad mapping, read-only
// - Overrun when buffer full, shift waiting, start
// - Zero first stop bit sets framing error
// - Parity checked only in kinds 1, 5, 7
// - Error flags travel with each buffered character
// - Error flags clear by one or receiver off
// - Count config write busy; rewrite gives bus error
// - Tally sync busy after error and wake-up
// - Second control write busy while unit enabled
// - Enable and soft reset writes set busy
// - Smart card counts parity plus NACK errors
// - Reading the tally clears it
// - Direction field selects off, transmit, receive counting
// - Count limit raises done flag with 32-bit access; zero reserved
// - Data port reads receive, writes transmit
// - Data sized 32 bits or character width
// - Halt-on-debug stops baud generator while halted
// - Any error flag setting raises summary error
package usr_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] IDX_STATUS = 8'h1a;
    localparam logic [7:0] IDX_SYNC = 8'h1c;
    localparam logic [7:0] IDX_TALLY = 8'h20;
    localparam logic [7:0] IDX_LEN = 8'h22;
    localparam logic [7:0] IDX_DATA = 8'h28;
    localparam logic [7:0] IDX_DBG = 8'h30;
    localparam int B_REPEAT_LIMIT_FLAG = 7;
    localparam int B_TXE = 6;
    localparam int B_BUS_CLASH_FLAG = 5;
    localparam int B_ISF = 4;
    localparam int B_CTS = 3;
    localparam int B_OVF = 2;
    localparam int B_FRAMING_ERROR_FLAG = 1;
    localparam int B_PARITY_ERROR_FLAG = 0;
    localparam int SB_SOFT_RESET_REQUEST = 0;
    localparam int SB_ENABLE = 1;
    localparam int SB_SECOND_CONTROL_REG = 2;
    localparam int SB_TALLY = 3;
    localparam int SB_LEN = 4;
    localparam int SB_N = 5;
    localparam int LEN_DIR_LO = 8;
    localparam int B_HALT = 0;
    localparam logic [3:0] FORM_PAR0 = 4'h1;
    localparam logic [3:0] FORM_PAR1 = 4'h5;
    localparam logic [3:0] FORM_SC = 4'h7;
    localparam logic [3:0] FORM_LIN_MASTER = 4'h2;
    localparam logic [3:0] FORM_AUTOBAUD = 4'h4;
    localparam logic [1:0] TXPO_FLOW = 2'h2;
    localparam logic [7:0] SYNC_FIELD = 8'h55;
    localparam logic [1:0] CDIR_OFF = 2'h0;
    localparam logic [1:0] CDIR_TX = 2'h1;
    localparam logic [1:0] CDIR_RX = 2'h2;
    localparam logic [7:0] LEN_RESV = 8'h00;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam int CLK_NS = 10;
    localparam int SYNC_NS = 30;
    localparam logic [1:0] SYNC_CYC = 2'((SYNC_NS + CLK_NS - 1) / CLK_NS);
endpackage : usr_pkg

// ==== hw/usr_regs.sv ====
// Status flags, sync-pending, error tally, length counter, data port, debug halt
module usr_regs (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [usr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] frame_kind_select,
    input wire logic clash_detect_enable,
    input wire logic [1:0] tx_pad_mapping,
    input wire logic wide_access_enable,
    input wire logic [2:0] char_width,
    input wire logic rx_enable,
    input wire logic unit_enabled,
    input wire logic soft_reset_request,
    input wire logic enable_write,
    input wire logic second_control_write,
    input wire logic wake_up,
    input wire logic cpu_debug_halted,
    input wire logic cts_pin,
    input wire logic repeat_limit_evt,
    input wire logic tx_idle_evt,
    input wire logic clash_evt,
    input wire logic sync_field_valid,
    input wire logic [7:0] sync_field_val,
    input wire logic rx_start_evt,
    input wire logic rx_shift_waiting,
    input wire logic rx_char_valid,
    input wire logic [31:0] rx_char_data,
    input wire logic rx_stop_bit,
    input wire logic rx_parity_bad,
    input wire logic nack_err_evt,
    input wire logic tx_taken,
    output logic [31:0] tx_holding_reg,
    output logic tx_holding_empty_flag,
    output logic rx_done_flag,
    output logic rx_buf_full,
    output logic length_done,
    output logic [usr_pkg::SB_N-1:0] sync_pending_out,
    output logic baud_halt,
    output logic error_flag_pulse
);
    import usr_pkg::*;

    logic [1:0] cts_sync_r;
    logic repeat_limit_flag_r, txe_r, bus_clash_flag_r, isf_r;
    logic [31:0] buf_data_r [2];
    logic [2:0] buf_err_r [2];
    logic rd_ptr_r;
    logic [1:0] cnt_r, cnt_nxt;
    logic [7:0] tally_r;
    logic [7:0] len_limit_r, len_cnt_r;
    logic [1:0] cdir_r;
    logic halt_on_debug_r;
    logic [31:0] tx_data_r;
    logic tx_valid_r, tx_empty_r;
    logic [1:0] sb_cnt_r [SB_N];
    logic [SB_N-1:0] sync_busy, sync_trig;
    logic [31:0] prdata_r;
    logic pslverr_r, rx_done_r, rx_full_r, len_done_r, halt_r, err_pulse_r, pready_r;

    logic [7:0] idx;
    logic setup, acc, acc_wr, acc_rd, st_wr, pop, push, wr_ptr;
    logic ovf_set, bus_clash_flag_set, isf_set, par_chk, tally_inc;
    logic [2:0] head_err;
    logic [15:0] status_val;
    logic [31:0] char_mask;

    // Full byte decode; halfword registers keep their own byte offsets
    assign idx = paddr;
    assign setup = psel && !penable;
    assign acc = psel && penable;
    assign acc_wr = acc && pwrite;
    assign acc_rd = acc && !pwrite;
    assign st_wr = acc_wr && idx == IDX_STATUS;
    assign head_err = buf_err_r[rd_ptr_r];
    assign wr_ptr = rd_ptr_r ^ cnt_r[0];
    assign pop = acc_rd && idx == IDX_DATA && cnt_r != 2'd0;
    assign push = rx_enable && rx_char_valid && (cnt_r != 2'd2 || pop);
    assign par_chk = frame_kind_select == FORM_PAR0 || frame_kind_select == FORM_PAR1
        || frame_kind_select == FORM_SC;
    assign ovf_set = rx_enable && rx_start_evt && cnt_r == 2'd2 && rx_shift_waiting;
    assign bus_clash_flag_set = clash_detect_enable && clash_evt;
    assign isf_set = frame_kind_select == FORM_AUTOBAUD && sync_field_valid
        && sync_field_val != SYNC_FIELD;
    assign tally_inc = frame_kind_select == FORM_SC
        && ((push && rx_parity_bad) || nack_err_evt);

    // Character width mask; 0 is 8 bits, 1 is 9 bits, 5..7 are literal
    always_comb begin
        char_mask = 32'h0000_00ff;
        if (wide_access_enable) begin
            char_mask = 32'hffff_ffff;
        end else if (char_width == 3'd1) begin
            char_mask = 32'h0000_01ff;
        end else if (char_width >= 3'd5) begin
            char_mask = ~(32'hffff_ffff << char_width);
        end
    end

    // CTS pin is asynchronous to the core clock
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cts_sync_r <= 2'b00;
        end else begin
            cts_sync_r <= {cts_sync_r[0], cts_pin};
        end
    end

    always_comb begin
        status_val = STATUS_RST;
        status_val[B_REPEAT_LIMIT_FLAG] = repeat_limit_flag_r;
        status_val[B_TXE] = txe_r && frame_kind_select == FORM_LIN_MASTER;
        status_val[B_BUS_CLASH_FLAG] = bus_clash_flag_r;
        status_val[B_ISF] = isf_r;
        status_val[B_CTS] = cts_sync_r[1] && tx_pad_mapping == TXPO_FLOW;
        status_val[B_OVF] = head_err[2];
        status_val[B_FRAMING_ERROR_FLAG] = head_err[1];
        status_val[B_PARITY_ERROR_FLAG] = head_err[0];
    end

    // Flags set by hardware win over a same-cycle clear
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            repeat_limit_flag_r <= 1'b0;
            txe_r <= 1'b0;
        end else begin
            if (st_wr && pwdata[B_REPEAT_LIMIT_FLAG]) begin
                repeat_limit_flag_r <= 1'b0;
            end
            if (repeat_limit_evt) begin
                repeat_limit_flag_r <= 1'b1;
            end
            if (st_wr && pwdata[B_TXE]) begin
                txe_r <= 1'b0;
            end
            if (frame_kind_select == FORM_LIN_MASTER && tx_idle_evt && !tx_valid_r) begin
                txe_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b || !rx_enable) begin
            bus_clash_flag_r <= 1'b0;
            isf_r <= 1'b0;
        end else begin
            if (st_wr && pwdata[B_BUS_CLASH_FLAG]) begin
                bus_clash_flag_r <= 1'b0;
            end
            if (bus_clash_flag_set) begin
                bus_clash_flag_r <= 1'b1;
            end
            if (st_wr && pwdata[B_ISF]) begin
                isf_r <= 1'b0;
            end
            if (isf_set) begin
                isf_r <= 1'b1;
            end
        end
    end

    always_comb begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 2'd1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 2'd1;
        end
        if (!rx_enable) begin
            cnt_nxt = 2'd0;
        end
    end

    // Two-entry receive buffer; each entry carries its own error bits
    always_ff @(posedge core_clk) begin
        if (!rst_b || !rx_enable) begin
            cnt_r <= 2'd0;
            rd_ptr_r <= 1'b0;
            buf_err_r[0] <= 3'b000;
            buf_err_r[1] <= 3'b000;
            buf_data_r[0] <= DATA_RST;
            buf_data_r[1] <= DATA_RST;
        end else begin
            cnt_r <= cnt_nxt;
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            if (st_wr) begin
                buf_err_r[rd_ptr_r] <= head_err & ~pwdata[2:0];
            end
            if (ovf_set) begin
                buf_err_r[rd_ptr_r][2] <= 1'b1;
            end
            if (push) begin
                buf_data_r[wr_ptr] <= rx_char_data;
                buf_err_r[wr_ptr] <= {1'b0, !rx_stop_bit, par_chk && rx_parity_bad};
            end
        end
    end

    // Read clears the tally, but an error in the same cycle still counts
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            tally_r <= BYTE_RST;
        end else if (acc_rd && idx == IDX_TALLY) begin
            tally_r <= {7'd0, tally_inc};
        end else if (tally_inc) begin
            tally_r <= tally_r + 8'd1;
        end
    end

    assign sync_trig[SB_SOFT_RESET_REQUEST] = soft_reset_request;
    assign sync_trig[SB_ENABLE] = enable_write;
    assign sync_trig[SB_SECOND_CONTROL_REG] = second_control_write && unit_enabled;
    assign sync_trig[SB_TALLY] = wake_up || tally_inc;
    assign sync_trig[SB_LEN] = acc_wr && idx == IDX_LEN && !pslverr_r;

    // Fixed crossing latency toward the core domain
    for (genvar i = 0; i < SB_N; i++) begin : g_sync
        logic busy_r;
        assign sync_busy[i] = busy_r;
        always_ff @(posedge core_clk) begin
            if (!rst_b) begin
                sb_cnt_r[i] <= 2'd0;
                busy_r <= 1'b0;
            end else if (sync_trig[i]) begin
                sb_cnt_r[i] <= SYNC_CYC;
                busy_r <= 1'b1;
            end else if (busy_r) begin
                sb_cnt_r[i] <= sb_cnt_r[i] - 2'd1;
                busy_r <= sb_cnt_r[i] != 2'd1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            len_limit_r <= BYTE_RST;
            cdir_r <= CDIR_OFF;
            halt_on_debug_r <= 1'b0;
        end else begin
            if (sync_trig[SB_LEN]) begin
                len_limit_r <= pwdata[7:0];
                cdir_r <= pwdata[LEN_DIR_LO+1:LEN_DIR_LO];
            end
            if (acc_wr && idx == IDX_DBG) begin
                halt_on_debug_r <= pwdata[B_HALT];
            end
        end
    end

    // Length counter; a zero limit is reserved and never fires
    always_ff @(posedge core_clk) begin
        if (!rst_b || sync_trig[SB_LEN]) begin
            len_cnt_r <= BYTE_RST;
            len_done_r <= 1'b0;
        end else begin
            len_done_r <= 1'b0;
            if (wide_access_enable && len_limit_r != LEN_RESV && acc && idx == IDX_DATA
                && ((cdir_r == CDIR_TX && pwrite) || (cdir_r == CDIR_RX && pop))) begin
                if (len_cnt_r + 8'd1 == len_limit_r) begin
                    len_cnt_r <= BYTE_RST;
                    len_done_r <= 1'b1;
                end else begin
                    len_cnt_r <= len_cnt_r + 8'd1;
                end
            end
        end
    end

    // New data written before the old is taken replaces it
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            tx_data_r <= DATA_RST;
            tx_valid_r <= 1'b0;
            tx_empty_r <= 1'b1;
        end else if (acc_wr && idx == IDX_DATA) begin
            tx_data_r <= pwdata & char_mask;
            tx_valid_r <= 1'b1;
            tx_empty_r <= 1'b0;
        end else if (tx_taken) begin
            tx_valid_r <= 1'b0;
            tx_empty_r <= 1'b1;
        end
    end

    // Read data is latched in the setup phase so every output is a flop
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            prdata_r <= DATA_RST;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            pslverr_r <= 1'b0;
            prdata_r <= DATA_RST;
            case (idx)
                IDX_STATUS: prdata_r <= {16'h0000, status_val};
                IDX_SYNC: prdata_r <= {27'd0, sync_busy};
                IDX_TALLY: prdata_r <= {24'd0, tally_r};
                IDX_LEN: begin
                    prdata_r <= {22'd0, cdir_r, len_limit_r};
                    pslverr_r <= pwrite && sync_busy[SB_LEN];
                end
                IDX_DATA: prdata_r <= buf_data_r[rd_ptr_r] & char_mask;
                IDX_DBG: prdata_r <= {31'd0, halt_on_debug_r};
                default: pslverr_r <= 1'b1;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rx_done_r <= 1'b0;
            rx_full_r <= 1'b0;
            halt_r <= 1'b0;
            err_pulse_r <= 1'b0;
            pready_r <= 1'b0;
        end else begin
            pready_r <= 1'b1;
            rx_done_r <= cnt_nxt != 2'd0;
            rx_full_r <= cnt_nxt == 2'd2;
            halt_r <= halt_on_debug_r && cpu_debug_halted;
            err_pulse_r <= bus_clash_flag_set || isf_set || ovf_set
                || (push && (!rx_stop_bit || (par_chk && rx_parity_bad)));
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign tx_holding_reg = tx_data_r;
    assign tx_holding_empty_flag = tx_empty_r;
    assign rx_done_flag = rx_done_r;
    assign rx_buf_full = rx_full_r;
    assign length_done = len_done_r;
    assign baud_halt = halt_r;
    assign error_flag_pulse = err_pulse_r;
    assign sync_pending_out = sync_busy;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    property p_repeat_limit_flag;
        repeat_limit_evt |=> repeat_limit_flag_r;
    endproperty
    a_repeat_limit_flag: assert property (p_repeat_limit_flag) else $error("repeat flag missed");

    property p_bus_clash_flag;
        bus_clash_flag_set && rx_enable |=> bus_clash_flag_r && status_val[B_BUS_CLASH_FLAG];
    endproperty
    a_bus_clash_flag: assert property (p_bus_clash_flag) else $error("clash flag missed");

    property p_ovf;
        ovf_set && !pop |=> status_val[B_OVF];
    endproperty
    a_ovf: assert property (p_ovf) else $error("overrun missed");

    property p_rxoff;
        !rx_enable |=> !bus_clash_flag_r && !isf_r && status_val[2:0] == 3'b000;
    endproperty
    a_rxoff: assert property (p_rxoff) else $error("flags kept with rx off");

    property p_lenerr;
        setup && pwrite && idx == IDX_LEN && sync_busy[SB_LEN] |=> pslverr_r;
    endproperty
    a_lenerr: assert property (p_lenerr) else $error("busy write not refused");

    property p_lenbusy;
        sync_trig[SB_LEN] |=> sync_busy[SB_LEN] [*3];
    endproperty
    a_lenbusy: assert property (p_lenbusy) else $error("busy too short");

    property p_tally;
        acc_rd && idx == IDX_TALLY && !tally_inc |=> tally_r == 8'd0;
    endproperty
    a_tally: assert property (p_tally) else $error("tally not cleared");

    property p_halt;
        halt_on_debug_r && cpu_debug_halted |=> baud_halt;
    endproperty
    a_halt: assert property (p_halt) else $error("baud not halted");

    property p_err;
        $rose(isf_r) |-> error_flag_pulse;
    endproperty
    a_err: assert property (p_err) else $error("summary error missed");
endmodule : usr_regs

// ==== testbench/usr_far_end.sv ====
// Far-side serial line model: received characters, line events and CTS level
module usr_far_end (
    input wire logic core_clk,
    output logic cts_pin,
    output logic [5:0] evt,
    output logic sync_field_valid,
    output logic [7:0] sync_field_val,
    output logic rx_shift_waiting,
    output logic rx_char_valid,
    output logic [31:0] rx_char_data,
    output logic rx_stop_bit,
    output logic rx_parity_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cts_pin, evt, sync_field_valid, sync_field_val, rx_shift_waiting} = '0;
        {rx_char_valid, rx_char_data, rx_stop_bit, rx_parity_bad} = '0;
    end
    task automatic pulse(input int i);
        @(posedge core_clk);
        evt[i] <= 1'b1;
        @(posedge core_clk);
        evt[i] <= 1'b0;
    endtask : pulse
    // Qualifiers flip after the strobe so stale data is never mistaken for a match
    task automatic send_char(input logic [31:0] d, input logic stop, input logic pbad);
        @(posedge core_clk);
        {rx_char_valid, rx_char_data, rx_stop_bit, rx_parity_bad} <= {1'b1, d, stop, pbad};
        @(posedge core_clk);
        {rx_char_valid, rx_char_data, rx_stop_bit, rx_parity_bad} <= {1'b0, ~d, ~stop, ~pbad};
    endtask : send_char
    task automatic send_sync(input logic [7:0] v);
        @(posedge core_clk);
        {sync_field_valid, sync_field_val} <= {1'b1, v};
        @(posedge core_clk);
        {sync_field_valid, sync_field_val} <= {1'b0, ~v};
    endtask : send_sync
    task automatic levels(input logic cts, input logic waiting);
        @(posedge core_clk);
        cts_pin <= cts;
        rx_shift_waiting <= waiting;
    endtask : levels
endmodule : usr_far_end

// ==== testbench/test_usart_status_sync_data_regs.sv ====
// Self-checking bench for the status, sync-pending, tally, length and data port block
module test_usart_status_sync_data_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import usr_pkg::*;
    logic core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, tx_holding_reg, rd, d;
    logic [3:0] frame_kind_select = 4'h0, trig = 4'h0;
    logic clash_detect_enable = 1'b0, wide_access_enable = 1'b1, rx_enable = 1'b1;
    logic unit_enabled = 1'b1, cpu_debug_halted = 1'b0, err, st, pready, pslverr;
    logic [1:0] tx_pad_mapping = 2'h0;
    logic [2:0] char_width = 3'h0;
    logic tx_holding_empty_flag, rx_done_flag, rx_buf_full, length_done, baud_halt;
    logic error_flag_pulse, cts_pin, sync_field_valid, rx_shift_waiting, rx_char_valid;
    logic rx_stop_bit, rx_parity_bad;
    logic [5:0] evt;
    logic [7:0] sync_field_val;
    logic [31:0] rx_char_data;
    logic [SB_N-1:0] sync_pending_out;
    logic [7:0] idx_tab [6] = '{IDX_STATUS, IDX_SYNC, IDX_TALLY, IDX_LEN, IDX_DATA, IDX_DBG};
    int miscompares = 0, n_checks = 0, n_len = 0, n_err = 0, cyc = 0, e0;
    int seed = 32'hfae9_2dae;

    usr_regs dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_kind_select(frame_kind_select),
        .clash_detect_enable(clash_detect_enable), .tx_pad_mapping(tx_pad_mapping),
        .wide_access_enable(wide_access_enable), .char_width(char_width),
        .rx_enable(rx_enable), .unit_enabled(unit_enabled), .soft_reset_request(trig[0]),
        .enable_write(trig[1]), .second_control_write(trig[2]), .wake_up(trig[3]),
        .cpu_debug_halted(cpu_debug_halted), .cts_pin(cts_pin), .repeat_limit_evt(evt[0]),
        .tx_idle_evt(evt[1]), .clash_evt(evt[2]), .sync_field_valid(sync_field_valid),
        .sync_field_val(sync_field_val), .rx_start_evt(evt[3]),
        .rx_shift_waiting(rx_shift_waiting), .rx_char_valid(rx_char_valid),
        .rx_char_data(rx_char_data), .rx_stop_bit(rx_stop_bit), .rx_parity_bad(rx_parity_bad),
        .nack_err_evt(evt[4]), .tx_taken(evt[5]), .tx_holding_reg(tx_holding_reg),
        .tx_holding_empty_flag(tx_holding_empty_flag), .rx_done_flag(rx_done_flag),
        .rx_buf_full(rx_buf_full), .length_done(length_done),
        .sync_pending_out(sync_pending_out), .baud_halt(baud_halt),
        .error_flag_pulse(error_flag_pulse));
    usr_far_end far (.core_clk(core_clk), .cts_pin(cts_pin), .evt(evt),
        .sync_field_valid(sync_field_valid), .sync_field_val(sync_field_val),
        .rx_shift_waiting(rx_shift_waiting), .rx_char_valid(rx_char_valid),
        .rx_char_data(rx_char_data), .rx_stop_bit(rx_stop_bit), .rx_parity_bad(rx_parity_bad));

    always #5 core_clk = ~core_clk;
    // One-cycle pulses are counted here so no single sample can miss them
    always @(posedge core_clk) begin
        cyc++;
        n_len += int'(length_done === 1'b1);
        n_err += int'(error_flag_pulse === 1'b1);
        if (cyc == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    function automatic logic [31:0] exp_err(input logic [3:0] k, input logic stop);
        return {30'h0, ~stop, (k == FORM_PAR0 || k == FORM_PAR1 || k == FORM_SC)};
    endfunction : exp_err
    function automatic logic [31:0] fmask(input logic [2:0] cw);
        case (cw)
            3'd1: return 32'h0000_01ff;
            3'd5: return 32'h0000_001f;
            3'd6: return 32'h0000_003f;
            3'd7: return 32'h0000_007f;
            default: return 32'h0000_00ff;
        endcase
    endfunction : fmask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge core_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, idx, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        check(rd, exp);
    endtask : rdchk
    task automatic ev_case(input logic [3:0] k, input logic cen, input int i,
                           input logic [7:0] exp);
        logic [7:0] v;
        v = (i == 6) ? SYNC_FIELD : SYNC_FIELD ^ (8'($random(seed)) | 8'h01);
        @(posedge core_clk);
        frame_kind_select <= k;
        clash_detect_enable <= cen;
        e0 = n_err;
        if (i < 6) far.pulse(i);
        else far.send_sync(v);
        tick(3);
        rdchk(IDX_STATUS, {24'h0, exp});
        check(32'(n_err - e0), 32'(|(exp & 8'h37)));
        apb(1'b1, IDX_STATUS, 32'h0000_00ff);
    endtask : ev_case
    task automatic complete_run();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        foreach (idx_tab[i]) rdchk(idx_tab[i], 32'h0000_0000);
        check(32'(pready), 32'h1);
        apb(1'b0, 8'h3f, 32'h0000_0000);
        check(32'(err), 32'h1);
        ev_case(FORM_SC, 1'b0, 0, 8'h80);
        far.pulse(0);
        apb(1'b1, IDX_STATUS, 32'h0000_0000);
        rdchk(IDX_STATUS, 32'h0000_0080);
        apb(1'b1, IDX_STATUS, 32'h0000_0080);
        rdchk(IDX_STATUS, 32'h0000_0000);
        ev_case(FORM_LIN_MASTER, 1'b0, 1, 8'h40);
        ev_case(FORM_PAR0, 1'b0, 1, 8'h00);
        ev_case(4'h0, 1'b1, 2, 8'h20);
        ev_case(4'h0, 1'b0, 2, 8'h00);
        ev_case(FORM_AUTOBAUD, 1'b0, 7, 8'h10);
        ev_case(FORM_AUTOBAUD, 1'b0, 6, 8'h00);
        tx_pad_mapping <= TXPO_FLOW;
        far.levels(1'b1, 1'b0);
        tick(4);
        apb(1'b1, IDX_STATUS, 32'h0000_0008);
        rdchk(IDX_STATUS, 32'h0000_0008);
        far.levels(1'b0, 1'b0);
        tick(4);
        rdchk(IDX_STATUS, 32'h0000_0000);
        for (int k = 0; k < 8; k++) begin
            @(posedge core_clk);
            frame_kind_select <= 4'(k);
            d = 32'($random(seed));
            st = 1'($random(seed));
            far.send_char(d, st, 1'b1);
            tick(2);
            rdchk(IDX_STATUS, exp_err(4'(k), st));
            rdchk(IDX_DATA, d);
            apb(1'b1, IDX_STATUS, 32'h0000_00ff);
        end
        tick(6);
        rdchk(IDX_TALLY, 32'h0000_0001);
        rdchk(IDX_TALLY, 32'h0000_0000);
        far.pulse(4);
        far.send_char(d, 1'b1, 1'b1);
        tick(6);
        rdchk(IDX_TALLY, 32'h0000_0002);
        rdchk(IDX_DATA, d);
        frame_kind_select <= 4'h0;
        far.send_char(32'h0000_00a5, 1'b0, 1'b0);
        far.send_char(d, 1'b1, 1'b0);
        tick(2);
        rdchk(IDX_STATUS, 32'h0000_0002);
        rdchk(IDX_DATA, 32'h0000_00a5);
        rdchk(IDX_STATUS, 32'h0000_0000);
        rdchk(IDX_DATA, d);
        far.send_char(d, 1'b1, 1'b0);
        far.send_char(~d, 1'b1, 1'b0);
        far.levels(1'b0, 1'b1);
        far.pulse(3);
        tick(2);
        rdchk(IDX_STATUS, 32'h0000_0004);
        check(32'(rx_buf_full), 32'h1);
        clash_detect_enable <= 1'b1;
        far.pulse(2);
        rx_enable <= 1'b0;
        tick(2);
        rdchk(IDX_STATUS, 32'h0000_0000);
        check(32'(rx_done_flag), 32'h0);
        rx_enable <= 1'b1;
        far.levels(1'b0, 1'b0);
        // Last pass writes the second control register with the unit disabled
        for (int i = 0; i < 5; i++) begin
            @(posedge core_clk);
            unit_enabled <= (i != 4);
            trig <= (i < 4) ? 4'(1 << i) : 4'h4;
            @(posedge core_clk);
            trig <= 4'h0;
            @(posedge core_clk);
            check(32'(sync_pending_out), (i < 4) ? 32'(1 << i) : 32'h0);
            tick(4);
            check(32'(sync_pending_out), 32'h0);
        end
        apb(1'b1, IDX_LEN, 32'h0000_0102);
        apb(1'b1, IDX_LEN, 32'h0000_0105);
        check(32'(err), 32'h1);
        tick(6);
        rdchk(IDX_LEN, 32'h0000_0102);
        for (int dir = 0; dir < 3; dir++) begin
            apb(1'b1, IDX_LEN, {22'h0, 2'(dir), 8'h01});
            tick(6);
            e0 = n_len;
            d = 32'($random(seed));
            apb(1'b1, IDX_DATA, d);
            far.send_char(~d, 1'b1, 1'b0);
            check(32'(tx_holding_empty_flag), 32'h0);
            rdchk(IDX_DATA, ~d);
            check(tx_holding_reg, d);
            far.pulse(5);
            tick(2);
            check(32'(tx_holding_empty_flag), 32'h1);
            check(32'(n_len - e0), 32'(dir != 0));
        end
        wide_access_enable <= 1'b0;
        for (int cw = 0; cw < 8; cw++) begin
            @(posedge core_clk);
            char_width <= 3'(cw);
            d = 32'($random(seed));
            apb(1'b1, IDX_DATA, d);
            tick(1);
            check(tx_holding_reg, d & fmask(3'(cw)));
            far.pulse(5);
        end
        cpu_debug_halted <= 1'b1;
        apb(1'b1, IDX_DBG, 32'h0000_00ff);
        rdchk(IDX_DBG, 32'h0000_0001);
        check(32'(baud_halt), 32'h1);
        cpu_debug_halted <= 1'b0;
        tick(2);
        check(32'(baud_halt), 32'h0);
        cpu_debug_halted <= 1'b1;
        apb(1'b1, IDX_DBG, 32'h0000_0000);
        tick(2);
        check(32'(baud_halt), 32'h0);
        complete_run();
    end
endmodule : test_usart_status_sync_data_regs
